// file: pkg/spi_port_cfg.svh
// constants of the serial port: register indices, field positions, reset values
// assumes a 32-bit apb slave; byte address of a register is four times its index
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

`define SPI_IDX_CONFIG 8'h30
`define SPI_IDX_CONTROL 8'h31
`define SPI_IDX_RXBUF 8'h37
`define SPI_IDX_DATA 8'h39
`define SPI_IDX_PRIORITY 8'h3f

`define SPI_CFG_SWRST_BIT 7
`define SPI_CFG_POL_BIT 6
`define SPI_CFG_RATE_HI 5
`define SPI_CFG_RATE_LO 3
`define SPI_CFG_LEN_HI 2
`define SPI_CFG_LEN_LO 0

`define SPI_CTL_OVR_BIT 7
`define SPI_CTL_FLAG_BIT 6
`define SPI_CTL_MASTER_BIT 2
`define SPI_CTL_TALK_BIT 1
`define SPI_CTL_IEN_BIT 0

`define SPI_PRI_LEVEL_BIT 6

`define SPI_CFG_RESET 8'h00
`define SPI_DATA_RESET 8'h00
`define SPI_BUF_RESET 8'h00

// half shift clock period is 4 << rate system clocks, so full period is 8 << rate
`define SPI_HALF_BASE 10'h004

`endif

// file: pkg/spi_port_pkg.sv
// types shared by the serial port design files
// assumes spi_port_cfg.svh supplies the numbers
package spi_port_pkg;
    typedef logic [7:0] char_t;
    typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_t;
endpackage : spi_port_pkg

// file: hw/spi_rate_prescaler.sv
// free-running prescaler giving one tick per half shift clock period
// assumes a single clock and active-low asynchronous reset
`timescale 1ns/10ps
`include "spi_port_cfg.svh"
module spi_rate_prescaler (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] rate_in,
    output logic tick_out
);
    logic [9:0] count;
    logic [9:0] mask;

    assign mask = (`SPI_HALF_BASE << rate_in) - 10'h001;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 10'h000;
        end else begin
            count <= count + 10'h001;
        end
    end

    // free running: first half period after a start may be short
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= ((count | ~mask) == 10'h3ff);
        end
    end
endmodule : spi_rate_prescaler

// file: hw/spi_master_slave_port.sv
// serial port core: apb register file, master clock generation, slave clock sync, shifter
// assumes pins synchronous to SYS_CLK_IN; testbench resolves pin wires from the enables
`timescale 1ns/10ps
`include "spi_port_cfg.svh"
module spi_master_slave_port (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic SERIAL_CLOCK_PIN_IN,
    output logic SERIAL_CLOCK_PIN_OUT,
    output logic SERIAL_CLOCK_PIN_OE_N_OUT,
    input wire logic SLAVE_IN_MASTER_OUT_PIN_IN,
    output logic SLAVE_IN_MASTER_OUT_PIN_OUT,
    output logic SLAVE_IN_MASTER_OUT_PIN_OE_N_OUT,
    input wire logic SLAVE_OUT_MASTER_IN_PIN_IN,
    output logic SLAVE_OUT_MASTER_IN_PIN_OUT,
    output logic SLAVE_OUT_MASTER_IN_PIN_OE_N_OUT,
    input wire logic IDLE_ENTRY_IN,
    output logic IRQ_LEVEL1_OUT,
    output logic IRQ_LEVEL2_OUT
);
    spi_port_pkg::char_t config_control_register;
    spi_port_pkg::char_t shift_data_register;
    spi_port_pkg::char_t receive_buffer_register;
    spi_port_pkg::char_t next_shift;
    spi_port_pkg::char_t read_mux;
    spi_port_pkg::xfer_state_t state;
    logic master_select;
    logic transmit_drive_enable;
    logic completion_irq_enable;
    logic completion_flag;
    logic receive_overrun_flag;
    logic irq_priority_select;
    logic soft_reset_bit;
    logic shift_clock_polarity;
    logic [2:0] bit_rate_select;
    logic [2:0] char_length_field;
    logic [2:0] bit_count;
    logic phase;
    logic sclk_level;
    logic data_out_bit;
    logic tick;
    logic sync_stage1;
    logic sync_stage2;
    logic sync_stage3;
    logic slave_lead;
    logic slave_trail;
    logic lead_edge;
    logic trail_edge;
    logic char_done;
    logic rx_bit;
    logic apb_access;
    logic apb_done;
    logic hit_config;
    logic hit_control;
    logic hit_rxbuf;
    logic hit_data;
    logic hit_priority;
    logic mapped;
    logic wr_en;
    logic rd_en;
    logic data_write;
    logic buf_read;

    assign soft_reset_bit = config_control_register[`SPI_CFG_SWRST_BIT];
    assign shift_clock_polarity = config_control_register[`SPI_CFG_POL_BIT];
    assign bit_rate_select = config_control_register[`SPI_CFG_RATE_HI:`SPI_CFG_RATE_LO];
    assign char_length_field = config_control_register[`SPI_CFG_LEN_HI:`SPI_CFG_LEN_LO];

    // apb decode: printed offsets are indices, byte address is index times four
    assign hit_config = (PADDR_IN == 8'({`SPI_IDX_CONFIG, 2'b00}));
    assign hit_control = (PADDR_IN == 8'({`SPI_IDX_CONTROL, 2'b00}));
    assign hit_rxbuf = (PADDR_IN == 8'({`SPI_IDX_RXBUF, 2'b00}));
    assign hit_data = (PADDR_IN == 8'({`SPI_IDX_DATA, 2'b00}));
    assign hit_priority = (PADDR_IN == 8'({`SPI_IDX_PRIORITY, 2'b00}));
    assign mapped = hit_config | hit_control | hit_rxbuf | hit_data | hit_priority;
    assign apb_access = PSEL_IN & PENABLE_IN;
    assign apb_done = apb_access & PREADY_OUT;
    assign wr_en = apb_done & PWRITE_IN & ~PSLVERR_OUT;
    assign rd_en = apb_done & ~PWRITE_IN & ~PSLVERR_OUT;
    // data register writes during soft reset are dropped
    assign data_write = wr_en & hit_data & ~soft_reset_bit;
    assign buf_read = rd_en & hit_rxbuf;

    always_comb begin
        read_mux = 8'h00;
        if (hit_config) begin
            read_mux = config_control_register;
        end else if (hit_control) begin
            read_mux = {receive_overrun_flag, completion_flag, 3'h0, master_select,
                        transmit_drive_enable, completion_irq_enable};
        end else if (hit_rxbuf) begin
            read_mux = receive_buffer_register;
        end else if (hit_data) begin
            read_mux = shift_data_register;
        end else if (hit_priority) begin
            read_mux = {1'b0, irq_priority_select, 6'h00};
        end
    end

    // one wait state so read data and error come from flip-flops
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else begin
            PREADY_OUT <= apb_access & ~PREADY_OUT;
            PSLVERR_OUT <= apb_access & ~PREADY_OUT & ~mapped;
            if (apb_access & ~PREADY_OUT) begin
                PRDATA_OUT <= {24'h00_0000, read_mux};
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            config_control_register <= `SPI_CFG_RESET;
            master_select <= 1'b0;
            transmit_drive_enable <= 1'b0;
            completion_irq_enable <= 1'b0;
            irq_priority_select <= 1'b0;
        end else if (wr_en) begin
            if (hit_config) begin
                config_control_register <= PWDATA_IN[7:0];
            end
            if (hit_control) begin
                master_select <= PWDATA_IN[`SPI_CTL_MASTER_BIT];
                transmit_drive_enable <= PWDATA_IN[`SPI_CTL_TALK_BIT];
                completion_irq_enable <= PWDATA_IN[`SPI_CTL_IEN_BIT];
            end
            if (hit_priority) begin
                irq_priority_select <= PWDATA_IN[`SPI_PRI_LEVEL_BIT];
            end
        end
    end

    spi_rate_prescaler spi_rate_prescaler_inst (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .rate_in(bit_rate_select),
        .tick_out(tick)
    );

    // external clock synchroniser; stage1 feeds stage2 only
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sync_stage1 <= 1'b0;
            sync_stage2 <= 1'b0;
            sync_stage3 <= 1'b0;
        end else begin
            sync_stage1 <= SERIAL_CLOCK_PIN_IN;
            sync_stage2 <= sync_stage1;
            sync_stage3 <= sync_stage2;
        end
    end

    // leading edge leaves the idle level, trailing edge returns to it
    assign slave_lead = ~master_select & ~soft_reset_bit & (sync_stage3 == shift_clock_polarity)
                        & (sync_stage2 != shift_clock_polarity);
    assign slave_trail = ~master_select & ~soft_reset_bit & (sync_stage3 != shift_clock_polarity)
                         & (sync_stage2 == shift_clock_polarity);
    // drive on one edge, sample on the other
    assign lead_edge = master_select ? (state == spi_port_pkg::XFER_SHIFT) & tick & ~phase : slave_lead;
    assign trail_edge = master_select ? (state == spi_port_pkg::XFER_SHIFT) & tick & phase : slave_trail;
    // slave takes data from the slave in pin
    assign rx_bit = master_select ? SLAVE_OUT_MASTER_IN_PIN_IN : SLAVE_IN_MASTER_OUT_PIN_IN;
    // new bit enters at the lsb, old bits move up
    assign next_shift = {shift_data_register[6:0], rx_bit};
    assign char_done = trail_edge & ~soft_reset_bit & (bit_count == char_length_field);

    // msb leaves first; writes mid-transfer take effect, corrupting it
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            shift_data_register <= `SPI_DATA_RESET;
        end else if (data_write) begin
            shift_data_register <= PWDATA_IN[7:0];
        end else if (trail_edge) begin
            shift_data_register <= next_shift;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bit_count <= 3'h0;
        end else if (soft_reset_bit) begin
            bit_count <= 3'h0;
        end else if (char_done) begin
            bit_count <= 3'h0;
        end else if (trail_edge) begin
            bit_count <= bit_count + 3'h1;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= spi_port_pkg::XFER_IDLE;
        end else begin
            case (state)
                spi_port_pkg::XFER_IDLE: begin
                    if (data_write & master_select) begin
                        state <= spi_port_pkg::XFER_SHIFT;
                    end
                end
                spi_port_pkg::XFER_SHIFT: begin
                    if (soft_reset_bit | ~master_select | char_done) begin
                        state <= spi_port_pkg::XFER_IDLE;
                    end
                end
                default: begin
                    state <= spi_port_pkg::XFER_IDLE;
                end
            endcase
        end
    end

    // clock toggles each half period tick
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            phase <= 1'b0;
        end else if (state != spi_port_pkg::XFER_SHIFT) begin
            phase <= 1'b0;
        end else if (tick) begin
            phase <= ~phase;
        end
    end

    // clock sits at the polarity level whenever not shifting
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sclk_level <= 1'b0;
        end else if (state != spi_port_pkg::XFER_SHIFT) begin
            sclk_level <= shift_clock_polarity;
        end else if (tick) begin
            sclk_level <= ~sclk_level;
        end
    end

    // data presented from the first edge
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            data_out_bit <= 1'b0;
        end else if (lead_edge) begin
            data_out_bit <= shift_data_register[7];
        end
    end

    // clock pin direction; data drivers float without transmit enable
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SERIAL_CLOCK_PIN_OE_N_OUT <= 1'b1;
            SLAVE_IN_MASTER_OUT_PIN_OE_N_OUT <= 1'b1;
            SLAVE_OUT_MASTER_IN_PIN_OE_N_OUT <= 1'b1;
        end else begin
            SERIAL_CLOCK_PIN_OE_N_OUT <= ~master_select;
            SLAVE_IN_MASTER_OUT_PIN_OE_N_OUT <= ~(master_select & transmit_drive_enable);
            SLAVE_OUT_MASTER_IN_PIN_OE_N_OUT <= ~(~master_select & transmit_drive_enable);
        end
    end

    assign SERIAL_CLOCK_PIN_OUT = sclk_level;
    assign SLAVE_IN_MASTER_OUT_PIN_OUT = data_out_bit;
    assign SLAVE_OUT_MASTER_IN_PIN_OUT = data_out_bit;

    // completed character copied to the buffer
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            receive_buffer_register <= `SPI_BUF_RESET;
        end else if (char_done) begin
            receive_buffer_register <= next_shift;
        end
    end

    // set wins over read or idle clear
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            completion_flag <= 1'b0;
        end else if (soft_reset_bit) begin
            completion_flag <= 1'b0;
        end else if (char_done) begin
            completion_flag <= 1'b1;
        end else if (buf_read | IDLE_ENTRY_IN) begin
            completion_flag <= 1'b0;
        end
    end

    // overrun when unread character is replaced
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            receive_overrun_flag <= 1'b0;
        end else if (soft_reset_bit) begin
            receive_overrun_flag <= 1'b0;
        end else if (char_done & completion_flag) begin
            receive_overrun_flag <= 1'b1;
        end
    end

    // priority steers the request; enable only masks
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            IRQ_LEVEL1_OUT <= 1'b0;
            IRQ_LEVEL2_OUT <= 1'b0;
        end else begin
            IRQ_LEVEL1_OUT <= completion_flag & completion_irq_enable & ~irq_priority_select;
            IRQ_LEVEL2_OUT <= completion_flag & completion_irq_enable & irq_priority_select;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_master_start;
        data_write && master_select && state == spi_port_pkg::XFER_IDLE;
    endsequence

    sequence s_done_unread;
        char_done && completion_flag;
    endsequence

    property p_start_shift;
        s_master_start |=> state == spi_port_pkg::XFER_SHIFT;
    endproperty
    a_start_shift: assert property (p_start_shift) else $error("master write did not start");

    property p_count_len;
        trail_edge && !soft_reset_bit |=> bit_count == (($past(bit_count) == $past(char_length_field)) ? 3'h0 : 3'($past(bit_count) + 3'h1));
    endproperty
    a_count_len: assert property (p_count_len) else $error("character ended at wrong count");

    property p_flag_set;
        char_done |=> completion_flag && receive_buffer_register == $past(next_shift);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("completion not recorded");

    property p_overrun;
        s_done_unread |=> receive_overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_irq_level;
        completion_flag && completion_irq_enable |=> (IRQ_LEVEL2_OUT == $past(irq_priority_select))
            && (IRQ_LEVEL1_OUT != $past(irq_priority_select));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("request on wrong level");

    property p_irq_mask;
        !completion_irq_enable |=> !IRQ_LEVEL1_OUT && !IRQ_LEVEL2_OUT;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked request raised");

    property p_soft_reset;
        soft_reset_bit |=> !completion_flag && !receive_overrun_flag
            && state == spi_port_pkg::XFER_IDLE ##1 sclk_level == $past(shift_clock_polarity);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

    property p_float;
        !transmit_drive_enable |=> SLAVE_IN_MASTER_OUT_PIN_OE_N_OUT && SLAVE_OUT_MASTER_IN_PIN_OE_N_OUT;
    endproperty
    a_float: assert property (p_float) else $error("data pin driven without enable");

    property p_flag_hold;
        completion_flag && !buf_read && !IDLE_ENTRY_IN && !soft_reset_bit |=> completion_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without cause");

    property p_idle_clock;
        state == spi_port_pkg::XFER_IDLE [*2] |-> sclk_level == $past(shift_clock_polarity);
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock not at idle level");
endmodule : spi_master_slave_port

// file: test/spi_far_end.sv
// far-side serial device: slave when the port is master, 32-clock master otherwise
// assumes start_in pulses once after the port is configured; pins resolved in the bench
`timescale 1ns/10ps
module spi_far_end (
    input wire logic clk_in,
    input wire logic master_in,
    input wire logic pol_in,
    input wire logic start_in,
    input wire logic [7:0] tx_in,
    input wire logic [3:0] len_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic sclk_out,
    output logic mosi_out,
    output logic miso_out,
    output logic [7:0] rx_out,
    output logic busy_out
);
    logic sclk_prev;
    logic [4:0] half_cnt;
    logic [4:0] edges;
    always_ff @(posedge clk_in) begin
        sclk_prev <= sclk_in;
        // released lines toggle so a stale level never passes
        if (master_in) miso_out <= ~miso_out;
        if (!(master_in && busy_out)) mosi_out <= ~mosi_out;
        if (start_in) begin
            rx_out <= tx_in;
            busy_out <= master_in;
            edges <= 5'h00;
            half_cnt <= 5'h00;
            sclk_out <= pol_in;
            mosi_out <= 1'b0;
            miso_out <= tx_in[7];
        end else if (master_in && busy_out) begin
            half_cnt <= half_cnt + 5'h01;
            // half period of 16 gives exactly system clock over 32
            if (half_cnt == 5'h0f) begin
                half_cnt <= 5'h00;
                // tail half holds the last bit past the final sample
                if (edges == {len_in, 1'b0}) begin
                    busy_out <= 1'b0;
                end else begin
                    sclk_out <= ~sclk_out;
                    edges <= edges + 5'h01;
                    // drive on the leading edge, sample on the trailing one
                    if (sclk_out == pol_in) mosi_out <= rx_out[7];
                    else rx_out <= {rx_out[6:0], miso_in};
                end
            end
        end else if (!master_in && sclk_in != sclk_prev) begin
            // slave shifts msb first against the port's clock
            if (sclk_in != pol_in) miso_out <= rx_out[7];
            else rx_out <= {rx_out[6:0], mosi_in};
        end
    end
endmodule : spi_far_end

// file: test/spi_master_slave_port_tb.sv
// self-checking bench: apb master, far-side model, pin resolution
// assumes the port answers apb with one wait state
`timescale 1ns/10ps
`include "spi_port_cfg.svh"
module spi_master_slave_port_tb;
    localparam logic [7:0] A_CFG = `SPI_IDX_CONFIG << 2;
    localparam logic [7:0] A_CTL = `SPI_IDX_CONTROL << 2;
    localparam logic [7:0] A_BUF = `SPI_IDX_RXBUF << 2;
    localparam logic [7:0] A_DAT = `SPI_IDX_DATA << 2;
    localparam logic [7:0] A_PRI = `SPI_IDX_PRIORITY << 2;
    logic clk, rst_n, psel, penable, pwrite, idle_entry, pready, pslverr, err, counting;
    logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, irq1, irq2;
    logic far_master, far_pol, far_start, far_sclk, far_mosi, far_miso, far_busy;
    logic [7:0] paddr, far_tx, far_rx;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] far_len;
    int err_count, compares, away;
    wire sclk_w = sclk_oe_n ? far_sclk : sclk_o;
    wire mosi_w = mosi_oe_n ? far_mosi : mosi_o;
    wire miso_w = miso_oe_n ? far_miso : miso_o;
    spi_master_slave_port spi_master_slave_port_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SERIAL_CLOCK_PIN_IN(sclk_w), .SERIAL_CLOCK_PIN_OUT(sclk_o),
        .SERIAL_CLOCK_PIN_OE_N_OUT(sclk_oe_n), .SLAVE_IN_MASTER_OUT_PIN_IN(mosi_w),
        .SLAVE_IN_MASTER_OUT_PIN_OUT(mosi_o), .SLAVE_IN_MASTER_OUT_PIN_OE_N_OUT(mosi_oe_n),
        .SLAVE_OUT_MASTER_IN_PIN_IN(miso_w), .SLAVE_OUT_MASTER_IN_PIN_OUT(miso_o),
        .SLAVE_OUT_MASTER_IN_PIN_OE_N_OUT(miso_oe_n), .IDLE_ENTRY_IN(idle_entry),
        .IRQ_LEVEL1_OUT(irq1), .IRQ_LEVEL2_OUT(irq2));
    spi_far_end spi_far_end_inst (.clk_in(clk), .master_in(far_master), .pol_in(far_pol), .start_in(far_start),
        .tx_in(far_tx), .len_in(far_len), .sclk_in(sclk_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .sclk_out(far_sclk), .mosi_out(far_mosi), .miso_out(far_miso), .rx_out(far_rx), .busy_out(far_busy));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (counting && sclk_w !== far_pol) away++;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task far_load(input logic m, input logic p, input logic [3:0] len, input logic [7:0] tx);
        @(posedge clk);
        far_master <= m;
        far_pol <= p;
        far_len <= len;
        far_tx <= tx;
        far_start <= 1'b1;
        @(posedge clk);
        far_start <= 1'b0;
    endtask : far_load
    task wait_irq;
        int n;
        n = 0;
        while (irq1 !== 1'b1 && irq2 !== 1'b1 && n < 10000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 10000) err_count++;
    endtask : wait_irq
    task poll(input logic [7:0] mask);
        int n;
        n = 0;
        apb(1'b0, A_CTL, 8'h00);
        while ((rd[7:0] & mask) != mask && n < 400) begin
            apb(1'b0, A_CTL, 8'h00);
            n++;
        end
        if (n >= 400) err_count++;
    endtask : poll
    task reset_values;
        apb(1'b0, A_CFG, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, A_CTL, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, A_DAT, 8'h00);
        check(rd, 32'h0);
        check({sclk_oe_n, mosi_oe_n, miso_oe_n, irq1, irq2}, 5'b11100);
        apb(1'b0, 8'h00, 8'h00);
        check(err, 1'b1);
    endtask : reset_values
    task master_run(input logic [2:0] k);
        logic [7:0] a, b;
        logic [15:0] t, u;
        int e;
        a = 8'h58 + 8'(k * 29);
        b = 8'hd0 - 8'(k * 13);
        t = {a, b} << (k + 1);
        u = {b, a} << (k + 1);
        e = (int'(k) + 1) * (4 << k);
        apb(1'b1, A_CFG, {1'b1, k[0], k, k});
        apb(1'b1, A_CFG, {1'b0, k[0], k, k});
        apb(1'b1, A_PRI, {1'b0, k[1], 6'h00});
        apb(1'b1, A_CTL, 8'h07);
        far_load(1'b0, k[0], 4'(k) + 4'h1, b);
        away = 0;
        counting = 1'b1;
        // character of k + 1 bits, written only while idle
        apb(1'b1, A_DAT, a);
        wait_irq();
        counting = 1'b0;
        check(away, e);
        check({sclk_oe_n, sclk_o}, {1'b0, k[0]});
        check({irq1, irq2}, k[1] ? 2'b01 : 2'b10);
        apb(1'b0, A_CTL, 8'h00);
        check(rd, 32'h47);
        apb(1'b0, A_BUF, 8'h00);
        check(rd, {24'h0, t[15:8]});
        check(far_rx, u[15:8]);
        repeat (2) @(negedge clk);
        check({irq1, irq2}, 2'b00);
    endtask : master_run
    task flags_run;
        apb(1'b1, A_CFG, 8'h87);
        apb(1'b1, A_CFG, 8'h07);
        apb(1'b1, A_PRI, 8'h00);
        far_load(1'b0, 1'b0, 4'h8, 8'h3c);
        apb(1'b1, A_DAT, 8'h11);
        poll(8'h40);
        far_load(1'b0, 1'b0, 4'h8, 8'h5a);
        apb(1'b1, A_DAT, 8'h22);
        poll(8'h80);
        check(rd, 32'hc7);
        apb(1'b0, A_BUF, 8'h00);
        check(rd, 32'h5a);
        far_load(1'b0, 1'b0, 4'h8, 8'h33);
        apb(1'b1, A_DAT, 8'h44);
        poll(8'h40);
        apb(1'b1, A_CTL, 8'h06);
        repeat (2) @(negedge clk);
        check(irq1, 1'b0);
        apb(1'b1, A_CTL, 8'h07);
        repeat (2) @(negedge clk);
        check(irq1, 1'b1);
        @(posedge clk);
        idle_entry <= 1'b1;
        @(posedge clk);
        idle_entry <= 1'b0;
        apb(1'b0, A_CTL, 8'h00);
        check(rd, 32'h87);
        apb(1'b1, A_CFG, 8'h87);
        apb(1'b0, A_CTL, 8'h00);
        check(rd, 32'h07);
        apb(1'b0, A_CFG, 8'h00);
        check({rd[7:0], sclk_o}, {8'h87, 1'b0});
        apb(1'b1, A_DAT, 8'h99);
        apb(1'b1, A_CFG, 8'h07);
        away = 0;
        counting = 1'b1;
        repeat (200) @(posedge clk);
        counting = 1'b0;
        check(away, 0);
        apb(1'b0, A_DAT, 8'h00);
        check(rd, 32'h33);
    endtask : flags_run
    task slave_run;
        apb(1'b1, A_CFG, 8'h87);
        apb(1'b1, A_CFG, 8'h07);
        apb(1'b1, A_CTL, 8'h03);
        apb(1'b1, A_DAT, 8'h96);
        far_load(1'b1, 1'b0, 4'h8, 8'h5a);
        wait_irq();
        apb(1'b0, A_BUF, 8'h00);
        check(rd, 32'h5a);
        check(far_rx, 8'h96);
        apb(1'b1, A_CTL, 8'h01);
        repeat (2) @(negedge clk);
        check({sclk_oe_n, miso_oe_n}, 2'b11);
    endtask : slave_run
    task summarize;
        $display("Checks made %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    initial begin
        #1200000;
        err_count++;
        summarize();
    end
    initial begin
        {rst_n, psel, penable, pwrite, idle_entry, counting, far_master, far_pol} = 8'h00;
        {paddr, pwdata, far_tx, far_len} = 52'h0;
        far_start = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        far_start <= 1'b0;
        reset_values();
        for (int i = 0; i < 8; i++) master_run(3'(i));
        flags_run();
        slave_run();
        summarize();
    end
endmodule : spi_master_slave_port_tb
